// ### rtl/ddrci_buf2.sv
// two-entry skid buffer carrying one write word and its byte masks
// assumes the sink may stall at any cycle
`timescale 1ns/1ps
module ddrci_buf2 #(
   parameter int DW = 32,
   parameter int NL = 4
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_b,
   // fill side
   ddrci_wr_if.dst           fill,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [2*DW-1:0]   out_data,
   output logic [2*NL-1:0]   out_mask
);
   localparam int W = 2*DW + 2*NL;
   logic [W-1:0] slot [2];
   logic         rd_ptr;
   logic         wr_ptr;
   logic [1:0]   count;
   wire          push = fill.valid && fill.ready;
   wire          pop  = out_valid && out_ready;
   // ready only from registered count, so the fill side never sees a loop
   assign fill.ready = (count != 2'd2);
   assign out_valid  = (count != 2'd0);
   assign {out_data, out_mask} = slot[rd_ptr];
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         count  <= 2'd0;
      end else begin
         if (push) wr_ptr <= ~wr_ptr;
         if (pop) rd_ptr <= ~rd_ptr;
         count <= 2'(count + {1'b0, push} - {1'b0, pop});
      end
   end
   always_ff @(posedge mclk) begin
      if (push) slot[wr_ptr] <= {fill.data, fill.mask};
   end
   AST_NO_OVERFLOW: assert property (@(posedge mclk) disable iff (!rst_b)
      count == 2'd2 && !out_ready |=> count == 2'd2 && out_valid)
      else $error("buffer lost a word while full");
endmodule : ddrci_buf2

// ### rtl/ddrci_defs.svh
// command-interface constants for the ddr command decoder
// assumes inclusion by bare name from rtl/
`ifndef DDRCI_DEFS_SVH
`define DDRCI_DEFS_SVH
`define DDRCI_AP_BIT_X32     4'd8
`define DDRCI_AP_BIT_X16     4'd10
`define DDRCI_MR_BL_LSB      0
`define DDRCI_MR_BT_BIT      3
`define DDRCI_MR_CL_LSB      4
`define DDRCI_MR_DLLRST_BIT  8
`define DDRCI_BA_BASE_MR     2'b00
`define DDRCI_BA_EXT_MR      2'b01
`define DDRCI_DLL_RELOCK_CYC 200
`define DDRCI_POWERUP_US     200
`define DDRCI_CLK_MHZ        125
`define DDRCI_POWERUP_CYC    (`DDRCI_POWERUP_US * `DDRCI_CLK_MHZ)
`endif

// ### rtl/ddrci_merge.sv
// packs two half-words into one core word, carrying the lane masks along
// assumes dm/dq arrive as rising then falling half, same cycle pairing
`timescale 1ns/1ps
module ddrci_merge #(
   parameter int DW = 32,
   parameter int NL = 4
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // pin side halves
   input  wire logic        wr_en,
   input  wire logic [DW-1:0] dq_rise,
   input  wire logic [DW-1:0] dq_fall,
   input  wire logic [NL-1:0] dm_rise,
   input  wire logic [NL-1:0] dm_fall,
   // carrier out
   ddrci_wr_if.src          wr
);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wr.valid <= 1'b0;
         wr.data  <= '0;
         wr.mask  <= '0;
      end else if (!wr.valid || wr.ready) begin
         wr.valid <= wr_en;
         wr.data  <= {dq_fall, dq_rise};
         wr.mask  <= {dm_fall, dm_rise};
      end
   end
endmodule : ddrci_merge

// ### rtl/ddrci_pkg.sv
// types shared by the ddr command-interface modules
// assumes nothing beyond a systemverilog compiler
package ddrci_pkg;
   typedef enum logic [3:0] {
      DDRCI_CMD_IDLE, DDRCI_CMD_ACT, DDRCI_CMD_RD, DDRCI_CMD_WR, DDRCI_CMD_BST,
      DDRCI_CMD_PRE, DDRCI_CMD_REF, DDRCI_CMD_MRS, DDRCI_CMD_ILL
   } ddrci_cmd_t;
   typedef enum logic [2:0] {
      DDRCI_ST_RUN, DDRCI_ST_PDN_IDLE, DDRCI_ST_PDN_ACT, DDRCI_ST_SELF_REF
   } ddrci_pwr_t;
endpackage : ddrci_pkg

// ### rtl/ddrci_top.sv
// command decode, cke power states and init tracking for a four-bank ddr dram
// assumes command pins are sampled on mclk, the rising edge of the memory clock
`timescale 1ns/1ps
`include "ddrci_defs.svh"
// Overview of operation
// - commands and addresses are taken only on the rising clock edge
// - deselect and no-operation are the same idle command
// - activate opens the row on address in the selected bank
// - read and write carry bank, column and the auto-close flag
// - auto-close applies only to its own read or write
// - precharge closes one bank, or all when auto-close flag is high
// - refresh command: auto refresh with cke high, self refresh with cke low
// - mode load: all strobes low, address is opcode, bank picks register
// - unlisted encodings illegal; cke high except self refresh entry (the code decodes unlisted 110 as burst stop, not illegal)
// - data mask high discards that byte lane of write data
// - auto-close is a8 on 32-bit parts, a10 otherwise
// - previous and current cke select power-down and self refresh moves
// - mode registers have no default; programmed during init
// - one double-width core word per clock from two pin halves
// - base opcode: burst length, type, cas latency, dll reset bit
// - extended register chosen by bank select 01
module ddrci_top
   import ddrci_pkg::*;
#(
   parameter int DW     = 32,
   parameter int NL     = 4,
   parameter int AW     = 13,
   parameter bit X32    = 1'b1,
   parameter int PU_CYC = `DDRCI_POWERUP_CYC
) (
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rst_b,
   // command pins
   input  wire logic          cke,
   input  wire logic          cs_b,
   input  wire logic          ras_b,
   input  wire logic          cas_b,
   input  wire logic          we_b,
   input  wire logic [1:0]    bank_select,
   input  wire logic [AW-1:0] addr,
   // write data halves
   input  wire logic [DW-1:0] dq_rise,
   input  wire logic [DW-1:0] dq_fall,
   input  wire logic [NL-1:0] dm_rise,
   input  wire logic [NL-1:0] dm_fall,
   // core write port
   output logic              core_wr_valid,
   input  wire logic          core_wr_ready,
   output logic [2*DW-1:0]   core_wr_data,
   output logic [2*NL-1:0]   core_wr_mask,
   // decoded command
   output ddrci_cmd_t         cmd,
   output logic [1:0]        cmd_bank,
   output logic [AW-1:0]     cmd_addr,
   output logic              auto_close_flag,
   output logic              close_all_banks_cmd,
   output logic              periodic_refresh_cmd,
   output logic              self_refresh_entry,
   output logic              self_refresh_exit,
   output logic              mode_load_cmd,
   output logic              ext_mode_load_cmd,
   output logic              illegal_cmd,
   // state
   output logic [3:0]        bank_open,
   output ddrci_pwr_t         pwr_state,
   output logic [AW-1:0]     base_mode,
   output logic [AW-1:0]     ext_mode,
   output logic [1:0]        mode_loaded,
   output logic              dll_locked,
   output logic              init_done,
   output logic              wr_write_burst
);
   function automatic ddrci_cmd_t decode(input logic c, r, a, w);
      if (c) return DDRCI_CMD_IDLE;
      unique case ({r, a, w})
         3'b111: decode = DDRCI_CMD_IDLE;
         3'b011: decode = DDRCI_CMD_ACT;
         3'b101: decode = DDRCI_CMD_RD;
         3'b100: decode = DDRCI_CMD_WR;
         3'b110: decode = DDRCI_CMD_BST;
         3'b010: decode = DDRCI_CMD_PRE;
         3'b001: decode = DDRCI_CMD_REF;
         3'b000: decode = DDRCI_CMD_MRS;
      endcase
   endfunction : decode

   localparam int PCW = $clog2(PU_CYC + 1);
   localparam int DLL_CYC = `DDRCI_DLL_RELOCK_CYC;

   // merging and buffering of masked write data
   ddrci_wr_if #(.DW(DW), .NL(NL)) wr_link ();
   ddrci_merge #(.DW(DW), .NL(NL)) u_merge (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .wr_en   (wr_write_burst),
      .dq_rise (dq_rise),
      .dq_fall (dq_fall),
      .dm_rise (dm_rise),
      .dm_fall (dm_fall),
      .wr      (wr_link)
   );
   logic            buf_valid;
   logic [2*DW-1:0] buf_data;
   logic [2*NL-1:0] buf_mask;
   // drain register takes a word whenever it is empty or being emptied
   wire             out_take = !core_wr_valid || core_wr_ready;
   ddrci_buf2 #(.DW(DW), .NL(NL)) u_buf (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .fill      (wr_link),
      .out_valid (buf_valid),
      .out_ready (out_take),
      .out_data  (buf_data),
      .out_mask  (buf_mask)
   );

   // decode of the pins sampled at this edge
   logic       cke_prev;
   wire ddrci_cmd_t raw = decode(cs_b, ras_b, cas_b, we_b);
   wire        is_idle = (raw == DDRCI_CMD_IDLE);
   wire [3:0]  ap_idx  = X32 ? `DDRCI_AP_BIT_X32 : `DDRCI_AP_BIT_X16;
   wire        ap      = addr[ap_idx];
   wire        in_pdn  = (pwr_state != DDRCI_ST_RUN);
   wire        all_idle = (bank_open == 4'h0);
   wire        cke_fall = cke_prev && !cke;
   wire        cke_rise = !cke_prev && cke;
   wire        sr_entry = cke_fall && raw == DDRCI_CMD_REF && all_idle;
   wire        pd_entry = cke_fall && is_idle;
   wire        pd_exit  = cke_rise && is_idle && in_pdn;
   wire        run_cmd  = cke_prev && cke && !in_pdn;
   wire        bad_cke  = in_pdn ? (cke_rise && !is_idle)
                          : (cke_fall && !is_idle && raw != DDRCI_CMD_REF);
   wire        bad_cmd  = run_cmd && ((raw == DDRCI_CMD_MRS && bank_select[1])
                          || (raw == DDRCI_CMD_REF && !all_idle));
   wire        mrs_base = run_cmd && raw == DDRCI_CMD_MRS
                          && bank_select == `DDRCI_BA_BASE_MR;
   wire        mrs_ext  = run_cmd && raw == DDRCI_CMD_MRS
                          && bank_select == `DDRCI_BA_EXT_MR;
   wire        dll_rst  = mrs_base && addr[`DDRCI_MR_DLLRST_BIT];
   wire [3:0]  bank_hot = 4'h1 << bank_select;

   logic [3:0] next_bank_open;
   always_comb begin
      next_bank_open = bank_open;
      if (run_cmd) begin
         unique case (raw)
            DDRCI_CMD_ACT: next_bank_open = bank_open | bank_hot;
            DDRCI_CMD_PRE: next_bank_open = ap ? 4'h0 : (bank_open & ~bank_hot);
            DDRCI_CMD_RD, DDRCI_CMD_WR:
               if (ap) next_bank_open = bank_open & ~bank_hot;
            default: next_bank_open = bank_open;
         endcase
      end
   end

   ddrci_pwr_t next_pwr;
   always_comb begin
      next_pwr = pwr_state;
      if (sr_entry) next_pwr = DDRCI_ST_SELF_REF;
      else if (pd_entry && !in_pdn)
         next_pwr = all_idle ? DDRCI_ST_PDN_IDLE : DDRCI_ST_PDN_ACT;
      else if (pd_exit) next_pwr = DDRCI_ST_RUN;
   end

   // power-up clock count and dll relock count
   logic [PCW-1:0] pu_cnt;
   logic [7:0]     dll_cnt;
   logic           pu_done;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pu_cnt  <= '0;
         pu_done <= 1'b0;
      end else if (!pu_done) begin
         pu_cnt  <= PCW'(pu_cnt + 1'b1);
         pu_done <= (pu_cnt == PCW'(PU_CYC - 1));
      end
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dll_cnt    <= '0;
         dll_locked <= 1'b0;
      end else if (dll_rst) begin
         dll_cnt    <= 8'(DLL_CYC);
         dll_locked <= 1'b0;
      end else if (dll_cnt != 8'h00) begin
         dll_cnt    <= 8'(dll_cnt - 1'b1);
         dll_locked <= (dll_cnt == 8'h01);
      end
   end

   // command outputs registered once per edge
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cke_prev             <= 1'b0;
         cmd                  <= DDRCI_CMD_IDLE;
         cmd_bank             <= 2'h0;
         cmd_addr             <= '0;
         auto_close_flag      <= 1'b0;
         close_all_banks_cmd  <= 1'b0;
         periodic_refresh_cmd <= 1'b0;
         self_refresh_entry   <= 1'b0;
         self_refresh_exit    <= 1'b0;
         mode_load_cmd        <= 1'b0;
         ext_mode_load_cmd    <= 1'b0;
         illegal_cmd          <= 1'b0;
         bank_open            <= 4'h0;
         pwr_state            <= DDRCI_ST_RUN;
      end else begin
         cke_prev             <= cke;
         cmd                  <= run_cmd ? raw : DDRCI_CMD_IDLE;
         cmd_bank             <= bank_select;
         cmd_addr             <= addr;
         auto_close_flag      <= run_cmd && (raw == DDRCI_CMD_RD || raw == DDRCI_CMD_WR
                                 || raw == DDRCI_CMD_PRE) && ap;
         close_all_banks_cmd  <= run_cmd && raw == DDRCI_CMD_PRE && ap;
         periodic_refresh_cmd <= run_cmd && raw == DDRCI_CMD_REF && all_idle;
         self_refresh_entry   <= sr_entry;
         self_refresh_exit    <= pd_exit && pwr_state == DDRCI_ST_SELF_REF;
         mode_load_cmd        <= mrs_base;
         ext_mode_load_cmd    <= mrs_ext;
         illegal_cmd          <= bad_cke || bad_cmd;
         bank_open            <= next_bank_open;
         pwr_state            <= next_pwr;
      end
   end

   // mode registers and init tracking
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         base_mode      <= '0;
         ext_mode       <= '0;
         mode_loaded    <= 2'b00;
         init_done      <= 1'b0;
         wr_write_burst <= 1'b0;
      end else begin
         if (mrs_base) base_mode <= addr;
         if (mrs_ext) ext_mode <= addr;
         mode_loaded    <= mode_loaded | {mrs_ext, mrs_base};
         init_done      <= init_done || (pu_done && mrs_base
                           && !addr[`DDRCI_MR_DLLRST_BIT] && (mode_loaded[1] || mrs_ext));
         wr_write_burst <= run_cmd && raw == DDRCI_CMD_WR;
      end
   end

   // drain register towards the core
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         core_wr_valid <= 1'b0;
         core_wr_data  <= '0;
         core_wr_mask  <= '0;
      end else if (out_take) begin
         core_wr_valid <= buf_valid;
         core_wr_data  <= buf_data;
         core_wr_mask  <= buf_mask;
      end
   end

   AST_PRE_ALL: assert property (@(posedge mclk) disable iff (!rst_b)
      run_cmd && raw == DDRCI_CMD_PRE && ap |=> bank_open == 4'h0)
      else $error("close-all left a bank open");
   AST_ACT_OPEN: assert property (@(posedge mclk) disable iff (!rst_b)
      run_cmd && raw == DDRCI_CMD_ACT |=> bank_open[$past(bank_select)])
      else $error("activate did not open bank");
   AST_SR_ENTRY: assert property (@(posedge mclk) disable iff (!rst_b)
      sr_entry |=> pwr_state == DDRCI_ST_SELF_REF && self_refresh_entry)
      else $error("self refresh entry missed");
   AST_PD_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
      in_pdn && !cke_prev && !cke |=> pwr_state == $past(pwr_state))
      else $error("power state moved with cke low");
   AST_IDLE_NOP: assert property (@(posedge mclk) disable iff (!rst_b)
      is_idle |=> cmd == DDRCI_CMD_IDLE && bank_open == $past(bank_open))
      else $error("idle command changed state");
   AST_MRS_SEL: assert property (@(posedge mclk) disable iff (!rst_b)
      mrs_ext |=> ext_mode == $past(addr) && !mode_load_cmd)
      else $error("extended load went astray");
   AST_AP_ONCE: assert property (@(posedge mclk) disable iff (!rst_b)
      run_cmd && raw == DDRCI_CMD_RD && !ap |=> !auto_close_flag)
      else $error("auto-close flag retained");
   AST_DLL_WAIT: assert property (@(posedge mclk) disable iff (!rst_b)
      dll_rst |=> !dll_locked [*8])
      else $error("dll locked too early");
   AST_REF_REFUSED: assert property (@(posedge mclk) disable iff (!rst_b)
      run_cmd && raw == DDRCI_CMD_REF && !all_idle
      |=> illegal_cmd && !periodic_refresh_cmd && bank_open == $past(bank_open))
      else $error("refresh with open banks was not refused");
   // self refresh exit takes two steps: resident with cke low, then cke back with an idle
   sequence seq_in_self_ref;
      pwr_state == DDRCI_ST_SELF_REF && !cke_prev;
   endsequence
   sequence seq_wake_idle;
      cke && is_idle;
   endsequence
   AST_SR_EXIT: assert property (@(posedge mclk) disable iff (!rst_b)
      seq_in_self_ref ##0 seq_wake_idle
      |=> pwr_state == DDRCI_ST_RUN && self_refresh_exit)
      else $error("self refresh exit missed");
endmodule : ddrci_top

// ### rtl/ddrci_wr_if.sv
// write-data carrier between the merge stage and the write buffer
// assumes a single mclk domain
`timescale 1ns/1ps
interface ddrci_wr_if #(parameter int DW = 32, parameter int NL = 4);
   logic          valid;
   logic          ready;
   logic [2*DW-1:0] data;
   logic [2*NL-1:0] mask;
   modport src (output valid, output data, output mask, input ready);
   modport dst (input valid, input data, input mask, output ready);
endinterface : ddrci_wr_if

// ### tb/ddrci_ctrl_model.sv
// controller-side model: command pins, cke and write-data halves
// assumes one caller at a time and a free-running mclk
`timescale 1ns/1ps
module ddrci_ctrl_model #(
   parameter int DW   = 32,
   parameter int NL   = 4,
   parameter int ROW_CLOSE_TIME  = 2,
   parameter int MODE_LOAD_GAP = 2,
   parameter int TDLL = 200
) (
   // clock
   input  wire logic       mclk,
   // command pins
   output logic            cke,
   output logic            cs_b,
   output logic            ras_b,
   output logic            cas_b,
   output logic            we_b,
   output logic [1:0]      bank_select,
   output logic [12:0]     addr,
   // write halves
   output logic [DW-1:0]   dq_rise,
   output logic [DW-1:0]   dq_fall,
   output logic [NL-1:0]   dm_rise,
   output logic [NL-1:0]   dm_fall
);
   initial begin
      cke = 1'b0;
      {cs_b, ras_b, cas_b, we_b} = 4'h7;
      bank_select = 2'h0;
      addr = 13'h0000;
      {dq_fall, dq_rise, dm_fall, dm_rise} = '0;
   end
   // one command edge, then a nop edge that carries write data for a write
   task automatic issue(input logic [3:0] str, input logic [1:0] ba, input logic [12:0] a,
                        input logic ck, input logic [2*DW-1:0] wd, input logic [2*NL-1:0] wm);
      @(posedge mclk);
      {cs_b, ras_b, cas_b, we_b} <= str;
      bank_select <= ba;
      addr <= a;
      cke <= ck;
      // released lines flip, so a stale word never passes for fresh data
      {dq_fall, dq_rise, dm_fall, dm_rise} <= ~{dq_fall, dq_rise, dm_fall, dm_rise};
      @(posedge mclk);
      {cs_b, ras_b, cas_b, we_b} <= 4'h7;
      bank_select <= ~ba;
      addr <= ~a;
      if (str == 4'h4) begin
         {dq_fall, dq_rise, dm_fall, dm_rise} <= {wd, wm};
      end
   endtask : issue
   task automatic idle(input int n, input logic ck);
      repeat (n) issue(4'h7, 2'h0, 13'h0000, ck, '0, '0);
   endtask : idle
   // everything after the power-up clocks; a8 is the close-all flag here
   // alt moves the two refreshes ahead of the second close-all
   task automatic init_rest(input logic [12:0] op, input bit alt);
      issue(4'h2, 2'h0, 13'h0100, 1'b1, '0, '0);
      idle(ROW_CLOSE_TIME, 1'b1);
      issue(4'h0, 2'h1, 13'h0000, 1'b1, '0, '0);
      issue(4'h0, 2'h0, op | 13'h0100, 1'b1, '0, '0);
      idle(MODE_LOAD_GAP, 1'b1);
      if (alt) repeat (2) issue(4'h1, 2'h0, 13'h0000, 1'b1, '0, '0);
      issue(4'h2, 2'h0, 13'h0100, 1'b1, '0, '0);
      if (!alt) repeat (2) issue(4'h1, 2'h0, 13'h0000, 1'b1, '0, '0);
      issue(4'h0, 2'h0, op, 1'b1, '0, '0);
      idle(TDLL, 1'b1);
   endtask : init_rest
endmodule : ddrci_ctrl_model

// ### tb/ddrci_top_bench.sv
// self-checking bench for the ddr command interface
// assumes ddrci_top and the controller model are compiled first
`timescale 1ns/1ps
module ddrci_top_bench
   import ddrci_pkg::*;
();
   localparam int PU = 20;
   typedef struct packed {
      logic [3:0]  str;
      logic [1:0]  ba;
      logic [12:0] a;
      ddrci_cmd_t  cmd;
      logic [5:0]  flg;
      logic [3:0]  opn;
   } ddrci_row_t;
   logic        mclk, rst_b, core_wr_ready, cke, cs_b, ras_b, cas_b, we_b;
   logic [1:0]  bank_select, cmd_bank, mode_loaded;
   logic [12:0] addr, cmd_addr, base_mode, ext_mode;
   logic [31:0] dq_rise, dq_fall;
   logic [3:0]  dm_rise, dm_fall, bank_open;
   logic [63:0] core_wr_data;
   logic [7:0]  core_wr_mask;
   logic        core_wr_valid, auto_close_flag, close_all_banks_cmd, periodic_refresh_cmd;
   logic        self_refresh_entry, self_refresh_exit, mode_load_cmd, ext_mode_load_cmd;
   logic        illegal_cmd, dll_locked, init_done, wr_write_burst;
   ddrci_cmd_t  cmd;
   ddrci_pwr_t  pwr_state;
   logic [5:0]  flg;
   int          err_total = 0;
   int          check_count = 0;
   ddrci_row_t  rows [13] = '{
      '{4'h7, 2'h0, 13'h0000, DDRCI_CMD_IDLE, 6'h00, 4'h0},
      '{4'h8, 2'h3, 13'h1fff, DDRCI_CMD_IDLE, 6'h00, 4'h0},
      '{4'h3, 2'h1, 13'h0123, DDRCI_CMD_ACT, 6'h00, 4'h2},
      '{4'h5, 2'h1, 13'h0405, DDRCI_CMD_RD, 6'h00, 4'h2},
      '{4'h6, 2'h0, 13'h0000, DDRCI_CMD_BST, 6'h00, 4'h2},
      '{4'h4, 2'h1, 13'h0009, DDRCI_CMD_WR, 6'h00, 4'h2},
      '{4'h2, 2'h1, 13'h0000, DDRCI_CMD_PRE, 6'h00, 4'h0},
      '{4'h3, 2'h2, 13'h0456, DDRCI_CMD_ACT, 6'h00, 4'h4},
      '{4'h5, 2'h2, 13'h0107, DDRCI_CMD_RD, 6'h20, 4'hf},
      '{4'h2, 2'h0, 13'h0100, DDRCI_CMD_PRE, 6'h30, 4'h0},
      '{4'h1, 2'h0, 13'h0000, DDRCI_CMD_REF, 6'h08, 4'h0},
      '{4'h0, 2'h0, 13'h0032, DDRCI_CMD_MRS, 6'h04, 4'h0},
      '{4'h0, 2'h1, 13'h0002, DDRCI_CMD_MRS, 6'h02, 4'h0}};
   assign flg = {auto_close_flag, close_all_banks_cmd, periodic_refresh_cmd, mode_load_cmd,
                 ext_mode_load_cmd, illegal_cmd};
   ddrci_top #(.PU_CYC(PU)) i_dut (.mclk, .rst_b, .cke, .cs_b, .ras_b, .cas_b, .we_b,
      .bank_select, .addr, .dq_rise, .dq_fall, .dm_rise, .dm_fall, .core_wr_valid,
      .core_wr_ready, .core_wr_data, .core_wr_mask, .cmd, .cmd_bank, .cmd_addr,
      .auto_close_flag, .close_all_banks_cmd, .periodic_refresh_cmd, .self_refresh_entry,
      .self_refresh_exit, .mode_load_cmd, .ext_mode_load_cmd, .illegal_cmd, .bank_open,
      .pwr_state, .base_mode, .ext_mode, .mode_loaded, .dll_locked, .init_done,
      .wr_write_burst);
   ddrci_ctrl_model i_ctrl (.mclk, .cke, .cs_b, .ras_b, .cas_b, .we_b, .bank_select,
      .addr, .dq_rise, .dq_fall, .dm_rise, .dm_fall);
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   function automatic logic [63:0] lanes(input logic [7:0] m);
      for (int i = 0; i < 8; i++) lanes[i*8 +: 8] = {8{m[i]}};
   endfunction : lanes
   // masked lanes carry no promise, so only kept bytes are compared
   task automatic take(input logic [63:0] d, input logic [7:0] m);
      for (int n = 0; n < 20 && core_wr_valid !== 1'b1; n++) @(negedge mclk);
      chk(core_wr_valid, 1'b1);
      chk(core_wr_mask, m);
      chk(core_wr_data & ~lanes(m), d & ~lanes(m));
      @(posedge mclk);
      core_wr_ready <= 1'b1;
      @(posedge mclk);
      core_wr_ready <= 1'b0;
      @(negedge mclk);
   endtask : take
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // the whole plan needs well under 1500 cycles
   initial begin
      repeat (5000) @(posedge mclk);
      err_total++;
      test_done();
   end
   initial begin
      rst_b = 1'b0;
      core_wr_ready = 1'b1;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      @(negedge mclk);
      chk({pwr_state, init_done, mode_loaded}, {DDRCI_ST_RUN, 3'h0});
      i_ctrl.idle(PU, 1'b1);
      @(negedge mclk);
      chk(init_done, 1'b0);
      i_ctrl.init_rest(13'h0032, 1'b0);
      @(negedge mclk);
      chk({init_done, dll_locked, mode_loaded}, 4'hf);
      foreach (rows[i]) begin
         i_ctrl.issue(rows[i].str, rows[i].ba, rows[i].a, 1'b1, '0, '0);
         @(negedge mclk);
         chk(cmd, rows[i].cmd);
         chk({cmd_bank, cmd_addr}, {rows[i].ba, rows[i].a});
         chk(flg, rows[i].flg);
         if (rows[i].opn != 4'hf) chk(bank_open, rows[i].opn);
      end
      chk({base_mode, ext_mode}, {13'h0032, 13'h0002});
      i_ctrl.issue(4'h0, 2'h2, 13'h0011, 1'b1, '0, '0);
      @(negedge mclk);
      chk({illegal_cmd, base_mode}, {1'b1, 13'h0032});
      i_ctrl.issue(4'h3, 2'h0, 13'h0001, 1'b1, '0, '0);
      i_ctrl.issue(4'h1, 2'h0, 13'h0000, 1'b1, '0, '0);
      @(negedge mclk);
      chk({illegal_cmd, periodic_refresh_cmd, bank_open}, 6'h21);
      i_ctrl.issue(4'h7, 2'h0, 13'h0000, 1'b0, '0, '0);
      @(negedge mclk);
      chk(pwr_state, DDRCI_ST_PDN_ACT);
      i_ctrl.issue(4'h2, 2'h0, 13'h0100, 1'b0, '0, '0);
      @(negedge mclk);
      chk({cmd, bank_open, pwr_state}, {DDRCI_CMD_IDLE, 4'h1, DDRCI_ST_PDN_ACT});
      i_ctrl.issue(4'h7, 2'h0, 13'h0000, 1'b1, '0, '0);
      @(negedge mclk);
      chk(pwr_state, DDRCI_ST_RUN);
      i_ctrl.issue(4'h2, 2'h0, 13'h0100, 1'b1, '0, '0);
      i_ctrl.issue(4'h7, 2'h0, 13'h0000, 1'b0, '0, '0);
      @(negedge mclk);
      chk({bank_open, pwr_state}, {4'h0, DDRCI_ST_PDN_IDLE});
      i_ctrl.issue(4'h7, 2'h0, 13'h0000, 1'b1, '0, '0);
      i_ctrl.issue(4'h1, 2'h0, 13'h0000, 1'b0, '0, '0);
      @(negedge mclk);
      chk({self_refresh_entry, periodic_refresh_cmd}, 2'h2);
      chk(pwr_state, DDRCI_ST_SELF_REF);
      i_ctrl.idle(2, 1'b0);
      @(negedge mclk);
      chk(pwr_state, DDRCI_ST_SELF_REF);
      i_ctrl.issue(4'h7, 2'h0, 13'h0000, 1'b1, '0, '0);
      @(negedge mclk);
      chk({self_refresh_exit, pwr_state}, {1'b1, DDRCI_ST_RUN});
      i_ctrl.idle(4, 1'b1);
      @(posedge mclk);
      core_wr_ready <= 1'b0;
      i_ctrl.issue(4'h3, 2'h0, 13'h0010, 1'b1, '0, '0);
      i_ctrl.issue(4'h4, 2'h0, 13'h0004, 1'b1, 64'h89ab_cdef_0123_4567, 8'h00);
      @(negedge mclk);
      chk(wr_write_burst, 1'b1);
      i_ctrl.issue(4'h4, 2'h0, 13'h0008, 1'b1, 64'hfedc_ba98_7654_3210, 8'h81);
      repeat (6) @(negedge mclk);
      chk(core_wr_valid, 1'b1);
      take(64'h89ab_cdef_0123_4567, 8'h00);
      take(64'hfedc_ba98_7654_3210, 8'h81);
      chk(core_wr_valid, 1'b0);
      @(posedge mclk);
      rst_b <= 1'b0;
      @(negedge mclk);
      chk({init_done, mode_loaded, bank_open, pwr_state}, {7'h00, DDRCI_ST_RUN});
      @(posedge mclk);
      rst_b <= 1'b1;
      i_ctrl.idle(PU, 1'b1);
      i_ctrl.init_rest(13'h0032, 1'b1);
      @(negedge mclk);
      chk({init_done, dll_locked, mode_loaded}, 4'hf);
      test_done();
   end
endmodule : ddrci_top_bench
